/* File: design/pim_mask_pending.sv */
// Primary interrupt mask and pending registers with APB access.
// Assumes source requests are level signals from logic on CLK_SYS.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns

// Operation
// RULE1: Mask bit per source, bits 8 to 18
// RULE2: Mask bit one blocks request to core
// RULE3: Mask bit zero forwards request to core
// RULE4: Masked request still shows as pending
// RULE5: Reset sets all defined mask bits
// RULE6: Software raises core level before masking
// RULE7: Pending bit per source, same order
// RULE8: Pending samples request every clock
// RULE9: Pending ignores the mask bit
// RULE10: Pending read-only, writes have no effect
// RULE11: Pending one means request present
// RULE12: Mask at 0x44, pending at 0x40
// RULE13: Unmasked request presented at programmed level
// RULE14: Core request is pending and not mask
module pim_mask_pending
    import pim_pkg::*;
#(
    parameter int N_SRC = NUM_SRC
)(
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST,
    input  wire pim_pkg::pim_apb_req_type      APB_REQ,
    output pim_pkg::pim_apb_rsp_type           APB_RSP,
    input  wire logic [N_SRC-1:0]              SRC_REQ,
    output logic      [N_SRC-1:0]              CORE_REQ,
    output logic      [pim_pkg::LEVEL_W-1:0]   CORE_IPL,
    output logic                               IRQ
);
    import pim_pkg::*;

    // ==========================================================
    // Declarations
    // ==========================================================
    // Register state, next value beside each
    logic [31:0]          mask_q;
    logic [31:0]          mask_d;
    logic [31:0]          pending_q;
    logic [31:0]          pending_d;
    logic [31:0]          evt_status_q;
    logic [31:0]          evt_status_d;
    logic [31:0]          evt_enable_q;
    logic [31:0]          evt_enable_d;
    logic [31:0]          level_low_q;
    logic [31:0]          level_low_d;
    logic [31:0]          level_high_q;
    logic [31:0]          level_high_d;
    // Bus answer and outputs toward the core
    pim_apb_rsp_type      rsp_q;
    pim_apb_rsp_type      rsp_d;
    logic [N_SRC-1:0]     core_req_q;
    logic [N_SRC-1:0]     core_req_d;
    logic                 irq_q;
    logic                 irq_d;
    // Per-source views and bus decode
    logic [N_SRC-1:0]     src_pend;
    logic [N_SRC-1:0]     src_mask;
    logic [N_SRC-1:0]     src_rise;
    logic [31:0]          rise_word;
    logic [N_SRC*LEVEL_W-1:0] src_level;
    logic [63:0]          level_both;
    logic                 setup_phase;
    logic                 wr_strobe;
    logic                 addr_hit;
    logic [31:0]          rd_mux;

    // ==========================================================
    // Per-source view of the register fields
    // ==========================================================
    assign level_both = {level_high_q, level_low_q};

    generate
        for (genvar i = 0; i < N_SRC; i++)
        begin : g_src
            // Field positions shared by both registers
            assign src_pend[i] = pending_q[FIRST_SRC_BIT + i];   // RULE7
            assign src_mask[i] = mask_q[FIRST_SRC_BIT + i];      // RULE1
            // New request seen by the pending register this clock
            assign src_rise[i] = SRC_REQ[i] & ~pending_q[FIRST_SRC_BIT + i];
            assign src_level[i*LEVEL_W +: LEVEL_W] =
                level_both[i*LEVEL_FIELD_W +: LEVEL_W];
        end
    endgenerate

    // Rising edges placed at the source bit positions
    // Reset clears pending, so a request held through reset still fires
    always_comb
    begin
        rise_word = '0;
        rise_word[FIRST_SRC_BIT +: N_SRC] = src_rise;
    end

    // ==========================================================
    // APB decode
    // ==========================================================
    // The answer is registered from the setup cycle, so every access completes with no wait state
    // No byte strobes: a write to mask, enable or level replaces the whole word
    assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
    assign wr_strobe   = APB_REQ.psel & APB_REQ.penable & rsp_q.pready & APB_REQ.pwrite;

    // Read mux and address check
    // Offsets outside the map answer with an error and read zero
    always_comb
    begin
        addr_hit = 1'b1;
        rd_mux   = '0;
        case (APB_REQ.paddr)
            OFS_INTERRUPT_PENDING: rd_mux = pending_q;          // RULE12
            OFS_INTERRUPT_MASK:    rd_mux = mask_q;             // RULE12
            OFS_EVENT_STATUS:      rd_mux = evt_status_q;
            OFS_EVENT_ENABLE:      rd_mux = evt_enable_q;
            OFS_LEVEL_LOW:         rd_mux = level_low_q;
            OFS_LEVEL_HIGH:        rd_mux = level_high_q;
            default:               addr_hit = 1'b0;
        endcase
    end

    // Response is prepared in setup and shown during access
    // Read data is the value held at the end of the setup cycle
    always_comb
    begin
        rsp_d         = '0;
        rsp_d.pready  = setup_phase;
        rsp_d.pslverr = setup_phase & ~addr_hit;
        if (setup_phase && !APB_REQ.pwrite)
        begin
            rsp_d.prdata = rd_mux;
        end
    end

    // Answer register; it clears the cycle after it is shown,
    // so pready is a single pulse and needs no extra state
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    // ==========================================================
    // Mask and level control registers
    // ==========================================================
    // Only defined bits store; reserved bits stay zero
    // Unmapped offsets fall through and leave every register alone
    always_comb
    begin
        mask_d       = mask_q;
        level_low_d  = level_low_q;
        level_high_d = level_high_q;
        if (wr_strobe)
        begin
            case (APB_REQ.paddr)
                OFS_INTERRUPT_MASK:
                begin
                    mask_d = APB_REQ.pwdata & SRC_FIELD_MASK;   // RULE2 RULE3 RULE14
                end
                OFS_LEVEL_LOW:
                begin
                    level_low_d = APB_REQ.pwdata & LEVEL_LOW_MASK;
                end
                OFS_LEVEL_HIGH:
                begin
                    level_high_d = APB_REQ.pwdata & LEVEL_HIGH_MASK;
                end
                default:
                begin
                    mask_d = mask_q;
                end
            endcase
        end
    end

    // Reset masks every source until software opens it
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            mask_q       <= MASK_RESET;                         // RULE5
            level_low_q  <= LEVEL_RESET;
            level_high_q <= LEVEL_RESET;
        end
        else
        begin
            mask_q       <= mask_d;
            level_low_q  <= level_low_d;
            level_high_q <= level_high_d;
        end
    end

    // ==========================================================
    // Pending register
    // ==========================================================
    // Follows the request lines every clock, mask and bus writes play no part
    // Writes to this offset complete normally but change nothing
    always_comb
    begin
        pending_d = '0;
        pending_d[FIRST_SRC_BIT +: N_SRC] = SRC_REQ;            // RULE8 RULE9 RULE10 RULE11
    end

    // A pulse shorter than one clock is missed; sources hold levels
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            pending_q <= PENDING_RESET;
        end
        else
        begin
            pending_q <= pending_d;                             // RULE4
        end
    end

    // ==========================================================
    // Request to the core
    // ==========================================================
    // Software must raise the core level before masking; a request
    // dropped here mid-acknowledge is otherwise seen as spurious
    always_comb
    begin
        core_req_d = src_pend & ~src_mask;                      // RULE14 RULE2 RULE3
    end

    // Registered so the core never sees a glitch from a mask write
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            core_req_q <= '0;
        end
        else
        begin
            core_req_q <= core_req_d;                           // RULE4
        end
    end

    // Level seen by the core, highest among the forwarded requests
    // Level zero keeps a source off this output; it still shows in CORE_REQ
    pim_level_encode #(
        .N      (N_SRC)
    ) u_level (
        .clk    (CLK_SYS),
        .rst    (RST),
        .req    (core_req_d),
        .level  (src_level),
        .ipl    (CORE_IPL)                                      // RULE13
    );

    // ==========================================================
    // Event status and interrupt line
    // ==========================================================
    // A new request wins over a write-one-to-clear in the same cycle
    // Only a rise of a request sets status; a held level fires once
    always_comb
    begin
        evt_status_d = evt_status_q;
        evt_enable_d = evt_enable_q;
        if (wr_strobe && (APB_REQ.paddr == OFS_EVENT_STATUS))
        begin
            evt_status_d = evt_status_q & ~APB_REQ.pwdata;
        end
        if (wr_strobe && (APB_REQ.paddr == OFS_EVENT_ENABLE))
        begin
            evt_enable_d = APB_REQ.pwdata & SRC_FIELD_MASK;
        end
        evt_status_d = (evt_status_d | rise_word) & SRC_FIELD_MASK;
        irq_d        = |(evt_status_d & evt_enable_d);
    end

    // Status, enable and the line itself share one register stage
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            evt_status_q <= EVENT_STATUS_RESET;
            evt_enable_q <= EVENT_ENABLE_RESET;
            irq_q        <= 1'b0;
        end
        else
        begin
            evt_status_q <= evt_status_d;
            evt_enable_q <= evt_enable_d;
            irq_q        <= irq_d;
        end
    end

    // ==========================================================
    // Outputs, all from flip-flops
    // ==========================================================
    // Plain wires from the registers above, no logic after the flops
    assign APB_RSP  = rsp_q;
    assign CORE_REQ = core_req_q;
    assign IRQ      = irq_q;

endmodule // pim_mask_pending

/* File: design/pim_pkg.sv */
// Package for the primary interrupt mask and pending block.
// Assumes a single system clock domain and an APB master with 32-bit data.
package pim_pkg;

    // ==========================================================
    // Source map
    // ==========================================================
    localparam int NUM_SRC        = 11;
    localparam int FIRST_SRC_BIT  = 8;
    localparam int LAST_SRC_BIT   = 18;
    localparam int LEVEL_W        = 3;
    localparam int LEVEL_FIELD_W  = 4;
    localparam int LEVELS_PER_REG = 8;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_PENDING = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_MASK    = 8'h44;
    localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS      = 8'h48;
    localparam logic [ADDR_W-1:0] OFS_EVENT_ENABLE      = 8'h4C;
    localparam logic [ADDR_W-1:0] OFS_LEVEL_LOW         = 8'h50;
    localparam logic [ADDR_W-1:0] OFS_LEVEL_HIGH        = 8'h54;

    // ==========================================================
    // Field layouts and reset values
    // ==========================================================
    localparam logic [31:0] SRC_FIELD_MASK     = 32'h0007FF00;
    localparam logic [31:0] MASK_RESET         = 32'h0007FF00;
    localparam logic [31:0] PENDING_RESET      = 32'h00000000;
    localparam logic [31:0] EVENT_STATUS_RESET = 32'h00000000;
    localparam logic [31:0] EVENT_ENABLE_RESET = 32'h00000000;
    localparam logic [31:0] LEVEL_RESET        = 32'h00000000;
    localparam logic [31:0] LEVEL_LOW_MASK     = 32'h77777777;
    localparam logic [31:0] LEVEL_HIGH_MASK    = 32'h00000777;

    // ==========================================================
    // Bus carriers
    // ==========================================================
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } pim_apb_req_type;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pim_apb_rsp_type;

endpackage

/* File: design/pim_level_encode.sv */
// Level encoder: highest level among the requests presented to the core.
// Assumes request and level inputs come from logic on the same clock.
`timescale 1ns/1ns
module pim_level_encode
    import pim_pkg::*;
#(
    parameter int N = 11
)(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [N-1:0]             req,
    input  wire logic [N*LEVEL_W-1:0]     level,
    output logic      [LEVEL_W-1:0]       ipl
);
    import pim_pkg::*;

    logic [LEVEL_W-1:0] ipl_d;
    logic [LEVEL_W-1:0] ipl_q;

    // ==========================================================
    // Maximum search; level zero means the source is switched off
    // ==========================================================
    always_comb
    begin
        ipl_d = '0;
        for (int i = 0; i < N; i++)
        begin
            if (req[i] && (level[i*LEVEL_W +: LEVEL_W] > ipl_d))
            begin
                ipl_d = level[i*LEVEL_W +: LEVEL_W];
            end
        end
    end

    // Registered so the core sees a glitch-free level
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ipl_q <= '0;
        end
        else
        begin
            ipl_q <= ipl_d;
        end
    end

    assign ipl = ipl_q;

endmodule // pim_level_encode

/* File: verif/pim_src_model.sv */
// Model of the on-chip modules that drive the source lines.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/1ns
module pim_src_model #(
    parameter int N = 11
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] want,
    output logic      [N-1:0] src_req
);
    logic [N-1:0] req_d;

    // Requests are levels, held while the cause lasts
    always_comb
    begin
        req_d = want;
    end

    // Launched from a flop on the same clock, so no extra sync
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            src_req <= '0;
        else
            src_req <= req_d;
    end
endmodule // pim_src_model

/* File: verif/pim_mask_pending_asserts.sv */
// Checker for the mask and pending block, bound to its top module.
// Assumes a well-formed APB master and one clock domain.
`timescale 1ns/1ns
module pim_mp_asserts #(
    parameter int N_SRC = pim_pkg::NUM_SRC
)(
    input wire logic                        CLK_SYS,
    input wire logic                        RST,
    input wire pim_pkg::pim_apb_req_type    APB_REQ,
    input wire pim_pkg::pim_apb_rsp_type    APB_RSP,
    input wire logic [N_SRC-1:0]            SRC_REQ,
    input wire logic [N_SRC-1:0]            CORE_REQ,
    input wire logic [pim_pkg::LEVEL_W-1:0] CORE_IPL,
    input wire logic                        IRQ
);
    import pim_pkg::*;
    // ====
    // Shadow mask fed by completed writes
    // ====
    logic [N_SRC-1:0] mask_q, mask_d;
    logic [1:0]       age_q, age_d;
    logic             acc, rd_done, wr_mask;
    logic [7:0]       a;

    assign a = APB_REQ.paddr;
    assign acc = APB_REQ.psel && APB_REQ.penable && APB_RSP.pready;
    assign rd_done = acc && !APB_REQ.pwrite;
    assign wr_mask = acc && APB_REQ.pwrite && a == OFS_INTERRUPT_MASK;

    // Age counter keeps reset-era history out of the forwarding check
    always_comb
    begin
        mask_d = wr_mask ? APB_REQ.pwdata[FIRST_SRC_BIT +: N_SRC] : mask_q;
        age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            mask_q <= '1;
            age_q  <= '0;
        end
        else
        begin
            mask_q <= mask_d;
            age_q  <= age_d;
        end
    end

    // ====
    // Properties
    // ====
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence setup_s;
        APB_REQ.psel && !APB_REQ.penable;
    endsequence
    sequence access_s;
        APB_REQ.psel && APB_REQ.penable && APB_RSP.pready;
    endsequence

    ready_next_a: assert property (setup_s |=> APB_RSP.pready)
        else $error("no ready one cycle after setup");
    ready_pulse_a: assert property (APB_RSP.pready |=> !APB_RSP.pready)
        else $error("ready longer than one cycle");
    slverr_map_a: assert property (access_s |-> APB_RSP.pslverr ==
        !(a inside {8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54}))
        else $error("error response wrong for address");
    mask_read_a: assert property (rd_done && a == OFS_INTERRUPT_MASK |->
        APB_RSP.prdata == (32'(mask_q) << FIRST_SRC_BIT))
        else $error("mask readback wrong");
    pend_read_a: assert property (rd_done && a == OFS_INTERRUPT_PENDING &&
        $stable(SRC_REQ) && SRC_REQ == $past(SRC_REQ, 2) && SRC_REQ == $past(SRC_REQ, 3)
        |-> APB_RSP.prdata == (32'(SRC_REQ) << FIRST_SRC_BIT))
        else $error("pending readback wrong");
    resv_zero_a: assert property (rd_done && a inside {8'h40, 8'h44} |->
        (APB_RSP.prdata & ~SRC_FIELD_MASK) == 32'h0)
        else $error("reserved bits not zero");
    core_fwd_a: assert property (age_q == 2'h3 |->
        CORE_REQ == ($past(SRC_REQ, 2) & ~$past(mask_q)))
        else $error("core request not pending and unmasked");
    ipl_idle_a: assert property (CORE_REQ == '0 |-> CORE_IPL == '0)
        else $error("level shown with no request");
endmodule // pim_mp_asserts

bind pim_mask_pending pim_mp_asserts #(.N_SRC(N_SRC)) i_chk (.CLK_SYS(CLK_SYS),
    .RST(RST), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .SRC_REQ(SRC_REQ),
    .CORE_REQ(CORE_REQ), .CORE_IPL(CORE_IPL), .IRQ(IRQ));

/* File: verif/pim_mask_pending_tb.sv */
// Testbench for the mask and pending block: APB calls with expected values.
// Assumes the checker is bound and the source model drives SRC_REQ.
`timescale 1ns/1ns
module pim_mask_pending_tb;
    import pim_pkg::*;
    logic               clk_sys, rst, irq, err;
    pim_apb_req_type    req;
    pim_apb_rsp_type    rsp;
    logic [NUM_SRC-1:0] want, src_req, core_req;
    logic [LEVEL_W-1:0] core_ipl;
    logic [31:0]        rd;
    int                 num_errors, n_checks;

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    pim_src_model #(.N(NUM_SRC)) i_src (.clk(clk_sys), .rst(rst), .want(want),
        .src_req(src_req));
    pim_mask_pending i_dut (.CLK_SYS(clk_sys), .RST(rst), .APB_REQ(req),
        .APB_RSP(rsp), .SRC_REQ(src_req), .CORE_REQ(core_req), .CORE_IPL(core_ipl),
        .IRQ(irq));

    // ====
    // Tasks
    // ====
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        // No cycle count assumed; a hang is left to the watchdog
        do
        begin
            @(posedge clk_sys);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog, far beyond the fewer than two hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        end_of_test;
    end

    // ====
    // Tests
    // ====
    initial
    begin
        req = '0;
        want = '0;
        rst = 1'b1;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        rdc("mask", OFS_INTERRUPT_MASK, MASK_RESET);
        rdc("pending", OFS_INTERRUPT_PENDING, 32'h0);
        $display("reset test done");
        want <= '1;
        repeat (4) @(posedge clk_sys);
        rdc("pending", OFS_INTERRUPT_PENDING, SRC_FIELD_MASK);
        chk("core", 32'(core_req), 32'h0);
        apb(1'b1, OFS_INTERRUPT_PENDING, 32'h0);
        rdc("pending", OFS_INTERRUPT_PENDING, SRC_FIELD_MASK);
        $display("masked test done");
        // Walk a single unmasked source through every position
        for (int i = 0; i < NUM_SRC; i++)
        begin
            apb(1'b1, OFS_INTERRUPT_MASK, SRC_FIELD_MASK & ~(32'h1 << (i + 8)));
            repeat (3) @(posedge clk_sys);
            chk("core", 32'(core_req), 32'h1 << i);
        end
        // Core level taken as raised already, so masking is safe here
        apb(1'b1, OFS_INTERRUPT_MASK, 32'hFFFFFFFF);
        repeat (3) @(posedge clk_sys);
        chk("core", 32'(core_req), 32'h0);
        rdc("mask", OFS_INTERRUPT_MASK, SRC_FIELD_MASK);
        apb(1'b0, 8'h60, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        $display("mask test done");
        want <= '0;
        apb(1'b1, OFS_EVENT_STATUS, 32'hFFFFFFFF);
        apb(1'b1, OFS_LEVEL_LOW, 32'h5);
        apb(1'b1, OFS_INTERRUPT_MASK, 32'h0);
        apb(1'b1, OFS_EVENT_ENABLE, 32'h100);
        chk("irq", 32'(irq), 32'h0);
        want <= 11'h1;
        repeat (4) @(posedge clk_sys);
        chk("ipl", 32'(core_ipl), 32'h5);
        chk("irq", 32'(irq), 32'h1);
        apb(1'b1, OFS_EVENT_ENABLE, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq", 32'(irq), 32'h0);
        want <= '0;
        apb(1'b1, OFS_EVENT_STATUS, 32'h100);
        apb(1'b1, OFS_EVENT_ENABLE, 32'h100);
        repeat (2) @(posedge clk_sys);
        chk("irq", 32'(irq), 32'h0);
        $display("interrupt test done");
        // Request rise and its clear land on one edge: the rise must win
        fork
            apb(1'b1, OFS_EVENT_STATUS, 32'h200);
            begin
                @(posedge clk_sys);
                want <= 11'h2;
            end
        join
        rdc("status", OFS_EVENT_STATUS, 32'h200);
        apb(1'b1, OFS_EVENT_ENABLE, 32'h200);
        repeat (2) @(posedge clk_sys);
        chk("irq", 32'(irq), 32'h1);
        // Two sources at different levels, one through the upper level register
        apb(1'b1, OFS_LEVEL_HIGH, 32'h600);
        want <= 11'h401;
        repeat (4) @(posedge clk_sys);
        chk("ipl", 32'(core_ipl), 32'h6);
        chk("core", 32'(core_req), 32'h401);
        rdc("pending", OFS_INTERRUPT_PENDING, 32'h40100);
        $display("level test done");
        // Reset again in mid-run with the mask open and IRQ high
        want <= '0;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rdc("mask", OFS_INTERRUPT_MASK, MASK_RESET);
        chk("core", 32'(core_req), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        $display("reset again test done");
        end_of_test;
    end
endmodule // pim_mask_pending_tb
